// File: sod_pkg.sv
// Shared constants and types for the speaker output diagnostic sequencer
package sod_pkg;
	localparam int          SOD_NCH        = 4;
	localparam int          SOD_CLK_HZ     = 50_000_000;
	localparam int          SOD_CHECK_MS   = 1;
	localparam int          SOD_CYCLE_MS   = 100;
	localparam int          SOD_CHECK_CYC  = SOD_CLK_HZ / 1000 * SOD_CHECK_MS;
	localparam int          SOD_CYCLE_CYC  = SOD_CLK_HZ / 1000 * SOD_CYCLE_MS;
	localparam int          SOD_AC_PULSES  = 3;
	localparam int          SOD_RD_BYTES   = 4;
	// Diagnostic byte field positions
	localparam int          SOD_B_GND      = 0;
	localparam int          SOD_B_SVS      = 1;
	localparam int          SOD_B_OPEN     = 2;
	localparam int          SOD_B_SLOAD    = 3;
	localparam int          SOD_B_PERM     = 4;
	localparam int          SOD_B_TWEET    = 5;
	localparam int          SOD_B_DONE     = 6;
	localparam int          SOD_B_THERM    = 7;
	localparam int          SOD_B_OFS_ACT  = 7;
	localparam int          SOD_B_AC_ACT   = 6;
	localparam logic [7:0]  SOD_BYTE_RST   = 8'h00;
	localparam logic [3:0]  SOD_FLT_RST    = 4'h0;

	typedef enum {
		TO_IDLE,
		TO_PULSE,
		TO_BIASED
	} sod_to_t;

	typedef enum {
		PM_RUN,
		PM_CHECK,
		PM_CYCLE,
		PM_RESTART
	} sod_pm_t;
endpackage

// File: sod_snap_mem.sv
// Read-back buffer: whole-image snapshot write, registered byte read
`timescale 1ns/10ps
module sod_snap_mem #(
	parameter int W = 8,
	parameter int D = 4
) (
	// Clock
	input  wire logic                   clk_sys_i,
	input  wire logic                   ce_i,
	// Snapshot write
	input  wire logic                   we_i,
	input  wire logic [W*D-1:0]         wdata_i,
	// Byte read
	input  wire logic [$clog2(D)-1:0]   raddr_i,
	output logic      [W-1:0]           rdata_o
);
	logic [W-1:0] mem [D];

	initial begin
		if (W < 1 || D < 2) begin
			$error("sod_snap_mem: unsupported geometry");
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (ce_i && we_i) begin
			for (int i = 0; i < D; i++) begin
				mem[i] <= wdata_i[i*W +: W];
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (ce_i) begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule

// File: sod_diag.sv
// Speaker output diagnostic sequencer: turn-on, permanent, offset and AC tests
`timescale 1ns/10ps
module sod_diag
	import sod_pkg::*;
#(
	parameter int NCH      = SOD_NCH,
	parameter int CHK_CYC  = SOD_CHECK_CYC,
	parameter int CYC_CYC  = SOD_CYCLE_CYC
) (
	// Clock and reset
	input  wire logic             clk_sys_i,
	input  wire logic             arst_n_i,
	input  wire logic             ce_i,
	// Decoded instruction bits
	input  wire logic             standby_off_i,
	input  wire logic             diag_en_i,
	input  wire logic             offset_en_i,
	input  wire logic             line_drv_sel_i,
	input  wire logic             ac_diag_en_i,
	input  wire logic [NCH-1:0]   gain_16db_i,
	// Analog comparators, one bit per channel except the shared thermal warning
	input  wire logic [NCH-1:0]   sgnd_src_i,
	input  wire logic [NCH-1:0]   sgnd_snk_i,
	input  wire logic [NCH-1:0]   svs_i,
	input  wire logic [NCH-1:0]   sload_i,
	input  wire logic [NCH-1:0]   oload_i,
	input  wire logic [NCH-1:0]   overload_i,
	input  wire logic [NCH-1:0]   offset_hi_i,
	input  wire logic [NCH-1:0]   cur_hi_pulse_i,
	input  wire logic             therm_warn_i,
	// Host read port
	input  wire logic             rd_start_i,
	input  wire logic [1:0]       rd_addr_i,
	output logic      [7:0]       rd_data_o,
	// Power stage control, comparator thresholds and done flag
	output logic                  pulse_on_o,
	output logic                  stage_bias_o,
	output logic      [NCH-1:0]   ch_off_o,
	output logic      [NCH-1:0]   thr_gain16_o,
	output logic      [NCH-1:0]   thr_line_o,
	output logic                  diag_done_o
);
	localparam int TW = $clog2(CYC_CYC + 1);
	localparam logic [TW-1:0] T_CHK = TW'(CHK_CYC);
	localparam logic [TW-1:0] T_CYC = TW'(CYC_CYC);

	initial begin
		if (NCH != SOD_RD_BYTES || CHK_CYC < 1 || CYC_CYC <= CHK_CYC) begin
			$error("sod_diag: unsupported parameters");
		end
	end

	// Resolve a raw fault set to {sload, open, svs, gnd}
	function automatic logic [3:0] prio(input logic so, input logic sk,
			input logic vs, input logic sl, input logic op);
		logic [3:0] r;
		r = 4'h0;
		if (vs) begin
			r[1] = 1'b1;
			r[0] = so;
		end else if (so) begin
			r[0] = 1'b1;
		end else if (sk && op) begin
			r[2] = 1'b1;
		end else if (sk) begin
			r[0] = 1'b1;
		end else if (sl) begin
			r[3] = 1'b1;
		end else if (op) begin
			r[2] = 1'b1;
		end
		return r;
	endfunction

	sod_to_t          to_reg;
	logic [TW-1:0]    to_tmr_reg;
	logic             to_armed_reg;
	logic             stby_d_reg;
	logic             ofs_en_d_reg;
	logic             ac_en_d_reg;
	logic             done_reg;
	logic [3:0]       flt_reg   [NCH];
	logic [NCH-1:0]   perm_reg;
	sod_pm_t          pm_reg    [NCH];
	logic [TW-1:0]    tmr_reg   [NCH];
	logic [NCH-1:0]   pm_armed_reg;
	logic [2:0]       acc_reg   [NCH];
	logic [NCH-1:0]   ofs_reg;
	logic [NCH-1:0]   ofs_res;
	logic [1:0]       acn_reg   [NCH];
	logic [NCH-1:0]   ac_ok_reg;
	logic [NCH-1:0]   cyc_end;
	logic             to_end;
	logic [NCH*8-1:0] snap;
	logic [7:0]       rd_q;

	assign to_end = (to_reg == TO_PULSE) && (to_tmr_reg == T_CYC - 1'b1);

	// Threshold selection for the analog comparators
	assign thr_gain16_o = gain_16db_i;
	assign thr_line_o   = gain_16db_i & {NCH{line_drv_sel_i}};

	// Turn-on sequence
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			to_reg     <= TO_IDLE;
			to_tmr_reg <= '0;
			stby_d_reg <= 1'b0;
		end else if (ce_i) begin
			stby_d_reg <= standby_off_i;
			unique case (to_reg)
				TO_IDLE: begin
					to_tmr_reg <= '0;
					if (standby_off_i && !stby_d_reg) begin
						// Pulse runs before bias while outputs float
						if (diag_en_i && to_armed_reg) begin
							to_reg <= TO_PULSE;
						end else begin
							to_reg <= TO_BIASED;
						end
					end
				end
				TO_PULSE: begin
					to_tmr_reg <= to_tmr_reg + 1'b1;
					if (!standby_off_i) begin
						to_reg <= TO_IDLE;
					end else if (to_end) begin
						to_reg <= TO_BIASED;
					end
				end
				TO_BIASED: begin
					if (!standby_off_i) begin
						to_reg <= TO_IDLE;
					end
				end
			endcase
		end
	end

	assign pulse_on_o   = (to_reg == TO_PULSE);
	assign stage_bias_o = (to_reg == TO_BIASED);

	// One pulse per read
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			to_armed_reg <= 1'b1;
		end else if (ce_i) begin
			if (rd_start_i) begin
				to_armed_reg <= 1'b1;
			end else if (to_end) begin
				to_armed_reg <= 1'b0;
			end
		end
	end

	// Permanent diagnostic per channel
	for (genvar c = 0; c < NCH; c++) begin : g_ch
		logic fault;
		assign fault      = overload_i[c];
		assign cyc_end[c] = (pm_reg[c] == PM_CYCLE) && (tmr_reg[c] == T_CYC - 1'b1);
		assign ch_off_o[c] = (pm_reg[c] != PM_RUN);

		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pm_reg[c]  <= PM_RUN;
				tmr_reg[c] <= '0;
				acc_reg[c] <= 3'h0;
			end else if (ce_i) begin
				unique case (pm_reg[c])
					PM_RUN: begin
						tmr_reg[c] <= '0;
						if (stage_bias_o && fault) begin
							// Protection fired; channel shut down alone
							if (diag_en_i && pm_armed_reg[c]) begin
								pm_reg[c] <= PM_CHECK;
							end else begin
								pm_reg[c] <= PM_RESTART;
							end
						end
					end
					PM_CHECK: begin
						tmr_reg[c] <= tmr_reg[c] + 1'b1;
						acc_reg[c] <= 3'h7;
						if (tmr_reg[c] == T_CHK - 1'b1) begin
							tmr_reg[c] <= '0;
							// Ignore recirculation spikes
							pm_reg[c] <= fault ? PM_CYCLE : PM_RUN;
						end
					end
					PM_CYCLE: begin
						tmr_reg[c] <= tmr_reg[c] + 1'b1;
						acc_reg[c] <= acc_reg[c] & {sload_i[c], svs_i[c],
							sgnd_src_i[c] | sgnd_snk_i[c]};
						if (cyc_end[c]) begin
							tmr_reg[c] <= '0;
							pm_reg[c]  <= PM_RESTART;
						end
					end
					PM_RESTART: begin
						tmr_reg[c] <= tmr_reg[c] + 1'b1;
						if (tmr_reg[c] == T_CHK - 1'b1) begin
							tmr_reg[c] <= '0;
							if (!fault) begin
								pm_reg[c] <= PM_RUN;
							end
						end
					end
				endcase
			end
		end

		// Fault image: turn-on capture, then permanent shorts only
		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				flt_reg[c]  <= SOD_FLT_RST;
				perm_reg[c] <= 1'b0;
			end else if (ce_i) begin
				if (to_end) begin
					flt_reg[c] <= prio(sgnd_src_i[c], sgnd_snk_i[c], svs_i[c],
						sload_i[c], oload_i[c]);
					perm_reg[c] <= 1'b0;
				end else if (cyc_end[c] && (acc_reg[c] != 3'h0)) begin
					// Open load not sensed here; the short that ends the cycle always clears the previous one
					flt_reg[c] <= prio(acc_reg[c][0], 1'b0, acc_reg[c][1],
						acc_reg[c][2], flt_reg[c][2]);
					perm_reg[c] <= 1'b1;
				end
			end
		end

		// One permanent cycle per read
		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				pm_armed_reg[c] <= 1'b1;
			end else if (ce_i) begin
				if (rd_start_i) begin
					pm_armed_reg[c] <= 1'b1;
				end else if (cyc_end[c]) begin
					pm_armed_reg[c] <= 1'b0;
				end
			end
		end

		// Offset and AC windows, restarted by each read
		always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
			if (!arst_n_i) begin
				ofs_reg[c]   <= 1'b0;
				acn_reg[c]   <= 2'h0;
				ac_ok_reg[c] <= 1'b0;
			end else if (ce_i) begin
				if (rd_start_i || (offset_en_i && !ofs_en_d_reg)) begin
					ofs_reg[c] <= offset_en_i;
				end else if (fault) begin
					ofs_reg[c] <= 1'b0;
				end else begin
					ofs_reg[c] <= ofs_reg[c] & offset_hi_i[c];
				end
				if (rd_start_i || (ac_diag_en_i && !ac_en_d_reg)) begin
					acn_reg[c]   <= 2'h0;
					ac_ok_reg[c] <= 1'b1;
				end else if (fault) begin
					// Suppressed: no open tweeter reported
					ac_ok_reg[c] <= 1'b0;
				end else if (cur_hi_pulse_i[c] && acn_reg[c] != 2'(SOD_AC_PULSES)) begin
					acn_reg[c] <= acn_reg[c] + 1'b1;
				end
			end
		end

		// Offset persisted over the whole window at read time
		assign ofs_res[c] = ofs_reg[c] & offset_en_i;

		// Snapshot byte for this channel
		always_comb begin
			snap[c*8 +: 8] = SOD_BYTE_RST;
			snap[c*8 + SOD_B_GND]   = flt_reg[c][0];
			snap[c*8 + SOD_B_SVS]   = flt_reg[c][1];
			snap[c*8 + SOD_B_OPEN]  = flt_reg[c][2] | ofs_res[c];
			snap[c*8 + SOD_B_SLOAD] = flt_reg[c][3];
			snap[c*8 + SOD_B_PERM]  = perm_reg[c];
			snap[c*8 + SOD_B_TWEET] = ac_diag_en_i && ac_ok_reg[c]
				&& (acn_reg[c] != 2'(SOD_AC_PULSES));
			if (c == 0) begin
				snap[c*8 + SOD_B_DONE]  = done_reg;
				snap[c*8 + SOD_B_THERM] = therm_warn_i;
			end else if (c == 1) begin
				snap[c*8 + SOD_B_AC_ACT]  = ac_diag_en_i;
				snap[c*8 + SOD_B_OFS_ACT] = offset_en_i;
			end
		end
	end

	// Enable edge history
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ofs_en_d_reg <= 1'b0;
			ac_en_d_reg  <= 1'b0;
		end else if (ce_i) begin
			ofs_en_d_reg <= offset_en_i;
			ac_en_d_reg  <= ac_diag_en_i;
		end
	end

	// Cycle-finished flag; a completion in the read cycle survives
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_reg <= 1'b0;
		end else if (ce_i) begin
			if (to_end || (|cyc_end)) begin
				done_reg <= 1'b1;
			end else if (rd_start_i) begin
				done_reg <= 1'b0;
			end
		end
	end

	assign diag_done_o = done_reg;

	// Image frozen at read start, so later bytes match the first
	sod_snap_mem #(
		.W (8),
		.D (NCH)
	) u_snap (
		.clk_sys_i (clk_sys_i),
		.ce_i      (ce_i),
		.we_i      (rd_start_i),
		.wdata_i   (snap),
		.raddr_i   (rd_addr_i),
		.rdata_o   (rd_q)
	);

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_o <= SOD_BYTE_RST;
		end else if (ce_i) begin
			rd_data_o <= rd_q;
		end
	end
endmodule

// File: sod_diag_assertions.sv
// Port-level checks for the diagnostic sequencer
`timescale 1ns/10ps
module sod_diag_chk
	import sod_pkg::*;
#(
	parameter int NCH     = SOD_NCH,
	parameter int CHK_CYC = SOD_CHECK_CYC,
	parameter int CYC_CYC = SOD_CYCLE_CYC
) (
	// Clock and reset
	input wire logic           clk_sys_i,
	input wire logic           arst_n_i,
	// Watched inputs
	input wire logic           standby_off_i,
	input wire logic           diag_en_i,
	input wire logic           line_drv_sel_i,
	input wire logic [NCH-1:0] gain_16db_i,
	input wire logic [NCH-1:0] overload_i,
	input wire logic           rd_start_i,
	// Watched outputs
	input wire logic           pulse_on_o,
	input wire logic           stage_bias_o,
	input wire logic [NCH-1:0] ch_off_o,
	input wire logic [NCH-1:0] thr_gain16_o,
	input wire logic [NCH-1:0] thr_line_o,
	input wire logic           diag_done_o
);
	// Worst wait: cycle started just before the overload clears, then one restart check
	localparam int RB = 2 * CHK_CYC + CYC_CYC + 8;
	int pcnt;
	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pcnt <= 0;
		end else begin
			pcnt <= pulse_on_o ? pcnt + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);
	a_gain_thr_follow: assert property (thr_gain16_o == gain_16db_i)
		else $error("load thresholds do not follow gain");
	a_line_thr_gate: assert property (thr_line_o == (gain_16db_i & {NCH{line_drv_sel_i}}))
		else $error("line thresholds wrongly selected");
	a_pulse_unbiased: assert property (pulse_on_o |-> !stage_bias_o)
		else $error("test pulse with stage biased");
	a_pulse_needs_req: assert property ($rose(pulse_on_o) |-> $past(diag_en_i) && $past(standby_off_i))
		else $error("test pulse without request");
	a_pulse_length: assert property ($fell(pulse_on_o) |->
		pcnt == CYC_CYC && stage_bias_o && diag_done_o)
		else $error("test pulse length or completion wrong");
	a_overload_off: assert property (stage_bias_o && overload_i[0] |=> ch_off_o[0])
		else $error("overloaded channel not shut down");
	a_restore_bound: assert property (ch_off_o[0] && !overload_i[0] |->
		##[0:RB] (!ch_off_o[0] || overload_i[0]))
		else $error("channel not restored after overload");
	a_done_clear_read: assert property ($fell(diag_done_o) |-> $past(rd_start_i))
		else $error("done cleared without read");
	a_done_cause: assert property ($rose(diag_done_o) |-> $past(pulse_on_o) || (|$past(ch_off_o)))
		else $error("done set without a cycle");
	c_turn_on: cover property ($fell(pulse_on_o));
	c_ch_off: cover property ($rose(ch_off_o[0]));
	c_read_clear: cover property ($fell(diag_done_o));
endmodule

bind sod_diag sod_diag_chk #(.NCH(NCH), .CHK_CYC(CHK_CYC), .CYC_CYC(CYC_CYC)) u_chk (
	.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .standby_off_i(standby_off_i), .diag_en_i(diag_en_i),
	.line_drv_sel_i(line_drv_sel_i), .gain_16db_i(gain_16db_i), .overload_i(overload_i),
	.rd_start_i(rd_start_i), .pulse_on_o(pulse_on_o), .stage_bias_o(stage_bias_o), .ch_off_o(ch_off_o),
	.thr_gain16_o(thr_gain16_o), .thr_line_o(thr_line_o), .diag_done_o(diag_done_o));

// File: sod_host.sv
// Host model: instruction bits and the read transfer
`timescale 1ns/10ps
module sod_host (
	// Clock
	input wire logic        clk_sys_i,
	// Instruction bits
	output logic            standby_off_o,
	output logic            diag_en_o,
	output logic            line_drv_sel_o,
	output logic            offset_en_o,
	output logic            ac_diag_en_o,
	// Read port
	output logic            rd_start_o,
	output logic [1:0]      rd_addr_o,
	input wire logic [7:0]  rd_data_i
);
	initial begin
		standby_off_o = 1'b0;
		diag_en_o = 1'b0;
		line_drv_sel_o = 1'b0;
		offset_en_o = 1'b0;
		ac_diag_en_o = 1'b0;
		rd_start_o = 1'b0;
		rd_addr_o = 2'h0;
	end
	task automatic mode(input logic sb, input logic de, input logic ld);
		standby_off_o = sb;
		diag_en_o = de;
		line_drv_sel_o = ld;
	endtask
	task automatic meas(input logic oe, input logic ae);
		offset_en_o = oe;
		ac_diag_en_o = ae;
	endtask
	// Address held three edges so the registered byte has surely settled
	task automatic read(output logic [7:0] b [4]);
		rd_start_o = 1'b1;
		@(posedge clk_sys_i);
		#2;
		rd_start_o = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rd_addr_o = 2'(i);
			repeat (3) @(posedge clk_sys_i);
			#2;
			b[i] = rd_data_i;
		end
	endtask
endmodule

// File: testbench.sv
// Self-checking bench for the diagnostic sequencer
`timescale 1ns/10ps
module testbench;
	localparam int CHK = 8;
	localparam int CYC = 64;
	logic       clk_sys_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic       sb, de, oe, ld, ae, rs, therm, pon, bias, done;
	logic [1:0] ra;
	logic [3:0] gain, so, sk, vs, sl, op, ovl, choff, tg, tl, ofh, chp;
	logic [7:0] rdd;
	logic [7:0] b [4];
	int         n_mismatch = 0;
	int         check_count = 0;
	int         seed = 32'h9ed6;
	int         cyc = 0;
	int         n, dflag;
	int         tos [4];
	int         ext [4];
	int         hits [4];
	always #10 clk_sys_i = ~clk_sys_i;
	sod_host u_host (.clk_sys_i(clk_sys_i), .standby_off_o(sb), .diag_en_o(de), .line_drv_sel_o(ld),
		.offset_en_o(oe), .ac_diag_en_o(ae), .rd_start_o(rs), .rd_addr_o(ra), .rd_data_i(rdd));
	sod_diag #(.NCH(4), .CHK_CYC(CHK), .CYC_CYC(CYC)) dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
		.ce_i(1'b1), .standby_off_i(sb), .diag_en_i(de), .offset_en_i(oe), .line_drv_sel_i(ld),
		.ac_diag_en_i(ae), .gain_16db_i(gain), .sgnd_src_i(so), .sgnd_snk_i(sk), .svs_i(vs), .sload_i(sl),
		.oload_i(op), .overload_i(ovl), .offset_hi_i(ofh), .cur_hi_pulse_i(chp), .therm_warn_i(therm),
		.rd_start_i(rs), .rd_addr_i(ra), .rd_data_o(rdd), .pulse_on_o(pon), .stage_bias_o(bias),
		.ch_off_o(choff), .thr_gain16_o(tg), .thr_line_o(tl), .diag_done_o(done));
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			end_sim();
		end
	end
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys_i);
		#2;
	endtask
	// Polls pulse (sel 0) or done (sel 1); n returns the edges spent
	task automatic wt(input int sel, input logic want);
		n = 0;
		while (((sel != 0) ? done : pon) !== want && n < 300) begin
			tick(1);
			n++;
		end
		chk("wait_level", 8'(n < 300), 8'h1);
	endtask
	// Expected turn-on flags for one channel
	function automatic int prio(input int c);
		if (vs[c]) return so[c] ? 3 : 2;
		if (so[c]) return 1;
		if (sk[c]) return op[c] ? 4 : 1;
		if (sl[c]) return 8;
		return op[c] ? 4 : 0;
	endfunction
	task automatic rdchk;
		u_host.read(b);
		for (int c = 0; c < 4; c++) begin
			chk("rd_data_o", b[c], 8'(tos[c] | ext[c]) | ((c == 0) ? {therm, dflag[0], 6'h0} : 8'h0));
		end
		dflag = 0;
	endtask
	initial begin
		{so, sk, vs, sl, op, ovl, gain, therm, ofh, chp} = '0;
		tick(6);
		arst_n_i = 1'b1;
		for (int k = 0; k < 3; k++) begin
			{so, sk, vs, sl, op, gain} = 24'($random(seed));
			therm = 1'($random(seed));
			u_host.mode(1'b0, 1'b1, gain[1]);
			tick(2);
			u_host.mode(1'b1, 1'b1, gain[1]);
			wt(0, 1'b1);
			wt(0, 1'b0);
			chk("pulse_len", 8'(n), 8'(CYC));
			chk("stage_bias_o", 8'(bias), 8'h1);
			chk("thr_gain16_o", 8'(tg), 8'(gain));
			chk("thr_line_o", 8'(tl), 8'(gain & {4{gain[1]}}));
			for (int c = 0; c < 4; c++) tos[c] = prio(c);
			dflag = 1;
			rdchk();
			rdchk();
		end
		u_host.mode(1'b0, 1'b0, 1'b0);
		tick(2);
		u_host.mode(1'b1, 1'b0, 1'b0);
		tick(4);
		chk("pulse_on_o", 8'(pon), 8'h0);
		u_host.mode(1'b1, 1'b1, 1'b0);
		{so, sk, sl} = '0;
		vs = 4'h1;
		op = 4'h1;
		ovl = 4'h1;
		wt(1, 1'b1);
		chk("cycle_len", 8'(n >= CHK + CYC - 2 && n <= CHK + CYC + 4), 8'h1);
		chk("ch_off_o", 8'(choff), 8'h1);
		ovl = 4'h0;
		tick(CHK + 4);
		chk("ch_off_o", 8'(choff), 8'h0);
		// Supply short dominates, so the old open bit goes
		tos[0] = prio(0) | 8'h10;
		dflag = 1;
		rdchk();
		rdchk();
		// Offset and tone window; one overload blip voids channel 3
		ofh = 4'($random(seed));
		u_host.meas(1'b1, 1'b1);
		tick(1);
		ovl = 4'h8;
		tick(1);
		ovl = 4'h0;
		for (int j = 0; j < 5; j++) begin
			chp = 4'($random(seed));
			for (int c = 0; c < 4; c++) hits[c] += chp[c];
			tick(1);
			chp = 4'h0;
			tick(1);
		end
		tick(CHK);
		chk("ch_off_o", 8'(choff), 8'h0);
		for (int c = 0; c < 4; c++) begin
			ext[c] = (c == 1) ? 'hc0 : 0;
			if (c != 3) ext[c] |= (ofh[c] ? 4 : 0) | ((hits[c] < 3) ? 'h20 : 0);
		end
		rdchk();
		// Windows restarted by that read: no pulses, no overload since
		for (int c = 0; c < 4; c++) ext[c] = ((c == 1) ? 'hc0 : 0) | (ofh[c] ? 4 : 0) | 'h20;
		rdchk();
		end_sim();
	end
endmodule
